// ===== src/tsa_pkg.sv
// Package: constants, encodings and carrier types of the temperature alarm
package tsa_pkg;
	localparam int CLK_MHZ = 200;
	localparam int CLK_NS = 5;
	localparam int TOUT_MS = 250;
	localparam int TOUT_CYC = TOUT_MS * 1000 * CLK_MHZ;
	localparam int TOUT_W = 32;
	localparam int RST_MIN_NS = 1000;
	localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int TEMP_W = 9;
	localparam logic [3:0] ADDR_BASE = 4'h9;
	localparam logic [1:0] PTR_TEMP = 2'h0;
	localparam logic [1:0] PTR_CFG = 2'h1;
	localparam logic [1:0] PTR_HYST = 2'h2;
	localparam logic [1:0] PTR_OS = 2'h3;
	localparam int CFG_SD = 0;
	localparam int CFG_INT = 1;
	localparam int CFG_POL = 2;
	localparam int CFG_FQ = 3;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [8:0] HYST_RST = 9'h096;
	localparam logic [8:0] OS_RST = 9'h0A0;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [2:0] FQ_SAT = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK
	} tsa_i2c_st_t;

	typedef struct packed {
		logic valid;
		logic [TEMP_W-1:0] temp;
	} tsa_conv_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic [2:0] sel;
	} tsa_pins_t;

	localparam tsa_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, sel: 3'h0};

	typedef struct packed {
		tsa_i2c_st_t st;
		logic scl_p;
		logic sda_p;
		logic [7:0] sh;
		logic [3:0] bcnt;
		logic rw;
		logic [1:0] wcnt;
		logic rhalf;
		logic [15:0] tx;
		logic sda_drv;
		logic [1:0] ptr;
		logic [7:0] cfg;
		logic [8:0] hyst;
		logic [8:0] os;
		logic [8:0] temp;
		logic alarm;
		logic look_hi;
		logic [2:0] ocnt;
		logic [2:0] ucnt;
		logic sd_p;
	} tsa_state_t;

	function automatic logic [2:0] tsa_fq_need(input logic [1:0] fq);
		unique case (fq)
			2'h0: tsa_fq_need = 3'h1;
			2'h1: tsa_fq_need = 3'h2;
			2'h2: tsa_fq_need = 3'h4;
			2'h3: tsa_fq_need = 3'h6;
		endcase
	endfunction : tsa_fq_need
endpackage : tsa_pkg

// ===== src/tsa_sync.sv
// Two-stage synchroniser for the bus and address select pins
`timescale 1ns/1ps
`default_nettype none
module tsa_sync
	import tsa_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire tsa_pins_t pins, // Raw pin levels
	output tsa_pins_t pins_s // Synchronised levels
);
	typedef struct packed {
		tsa_pins_t m;
		tsa_pins_t o;
	} tsa_sync_t;
	tsa_sync_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.m = pins;
		s_d.o = s_q.m;
	end

	// Idle bus level on reset so no false start is seen at release
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s_q <= {PINS_IDLE, PINS_IDLE};
		end else begin
			s_q <= s_d;
		end
	end

	assign pins_s = s_q.o;
endmodule : tsa_sync
`default_nettype wire

// ===== src/tsa_tout.sv
// Bus lockup timer: fires when the data line stays low too long
`timescale 1ns/1ps
`default_nettype none
module tsa_tout
	import tsa_pkg::*;
#(
	parameter logic [TOUT_W-1:0] LIMIT = TOUT_W'(TOUT_CYC)
) (
	input wire logic mclk, // System clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic line_low, // Synchronised data line is low
	output logic fire // One-cycle timeout pulse
);
	typedef struct packed {
		logic [TOUT_W-1:0] cnt;
		logic fire;
	} tsa_tout_t;
	tsa_tout_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.fire = 1'b0;
		if (!line_low) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= LIMIT) begin
			s_d.cnt = '0;
			s_d.fire = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fire = s_q.fire;
endmodule : tsa_tout
`default_nettype wire

// ===== src/tsa_top.sv
// Temperature alarm block: two-wire slave, registers and alarm logic
`timescale 1ns/1ps
`default_nettype none
module tsa_top
	import tsa_pkg::*;
#(
	parameter logic [TOUT_W-1:0] TOUT_LIMIT = TOUT_W'(TOUT_CYC)
) (
	input wire logic mclk, // System clock, 200 MHz
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic scl_i, // Serial clock pin level
	input wire logic sda_i, // Serial data pin level
	output logic sda_o, // Serial data drive value
	output logic sda_oe, // Serial data drive enable
	input wire logic [2:0] addr_sel, // Address select pins
	input wire tsa_conv_t conv, // Conversion result and strobe
	output logic alarm_output_o, // Alarm pin drive value
	output logic alarm_output_oe, // Alarm pin drive enable
	output logic shutdown // Low-power request to converter
);
	tsa_state_t s, n;
	tsa_pins_t pins_raw, pins_s;
	logic tout_fire;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic rd_done, rd_load, ptr_wr, cfg_wr, sd_enter;
	logic conv_eval, over, under, trip_hi, trip_lo;
	logic [2:0] need;
	logic [15:0] word, sh_tx;

	assign pins_raw = '{scl: scl_i, sda: sda_i, sel: addr_sel};

	tsa_sync u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.pins(pins_raw),
		.pins_s(pins_s)
	);

	tsa_tout #(
		.LIMIT(TOUT_LIMIT)
	) u_tout (
		.mclk(mclk),
		.rst_b(rst_b),
		.line_low(~pins_s.sda),
		.fire(tout_fire)
	);

	// Word presented for the selected register, upper byte first
	always_comb begin
		unique case (s.ptr)
			PTR_TEMP: word = {s.temp, 7'h00};
			PTR_CFG: word = {s.cfg, s.cfg};
			PTR_HYST: word = {s.hyst, 7'h00};
			PTR_OS: word = {s.os, 7'h00};
		endcase
	end

	always_comb begin
		n = s;
		rd_done = 1'b0;
		rd_load = 1'b0;
		ptr_wr = 1'b0;
		cfg_wr = 1'b0;
		sh_tx = s.tx << 1;
		n.scl_p = pins_s.scl;
		n.sda_p = pins_s.sda;
		scl_rise = pins_s.scl & ~s.scl_p;
		scl_fall = ~pins_s.scl & s.scl_p;
		start_c = pins_s.scl & s.scl_p & s.sda_p & ~pins_s.sda;
		stop_c = pins_s.scl & s.scl_p & ~s.sda_p & pins_s.sda;

		// A read in progress freezes the temperature register
		if (conv.valid && !s.cfg[CFG_SD] &&
				s.st != ST_RBYTE && s.st != ST_RACK) begin
			n.temp = conv.temp;
		end

		unique case (s.st)
			ST_IDLE: begin
				n.sda_drv = 1'b0;
			end
			ST_ADDR: begin
				if (scl_rise) begin
					n.sh = {s.sh[6:0], pins_s.sda};
					n.bcnt = s.bcnt + 4'h1;
				end else if (scl_fall && s.bcnt == BITS_BYTE) begin
					n.bcnt = 4'h0;
					if (s.sh[7:1] == {ADDR_BASE, pins_s.sel}) begin
						n.st = ST_AACK;
						n.sda_drv = 1'b1;
						n.rw = s.sh[0];
					end else begin
						n.st = ST_IDLE;
					end
				end
			end
			ST_AACK: begin
				if (scl_fall) begin
					n.bcnt = 4'h0;
					if (s.rw) begin
						// Reads start at the latched pointer
						rd_load = 1'b1;
						n.tx = word;
						n.rhalf = 1'b0;
						n.sda_drv = ~word[15];
						n.st = ST_RBYTE;
					end else begin
						n.wcnt = 2'h0;
						n.sda_drv = 1'b0;
						n.st = ST_WBYTE;
					end
				end
			end
			ST_WBYTE: begin
				if (scl_rise) begin
					n.sh = {s.sh[6:0], pins_s.sda};
					n.bcnt = s.bcnt + 4'h1;
				end else if (scl_fall && s.bcnt == BITS_BYTE) begin
					n.bcnt = 4'h0;
					n.sda_drv = 1'b1;
					n.st = ST_WACK;
					if (s.wcnt != 2'h3) begin
						n.wcnt = s.wcnt + 2'h1;
					end
					unique case (s.wcnt)
						2'h0: begin
							n.ptr = s.sh[1:0];
							ptr_wr = 1'b1;
						end
						2'h1, 2'h2: begin
							if (s.ptr == PTR_CFG) begin
								n.cfg = s.sh;
								cfg_wr = 1'b1;
							end else if (s.ptr == PTR_HYST) begin
								if (s.wcnt == 2'h1) begin
									n.hyst[8:1] = s.sh;
								end else begin
									n.hyst[0] = s.sh[7];
								end
							end else if (s.ptr == PTR_OS) begin
								if (s.wcnt == 2'h1) begin
									n.os[8:1] = s.sh;
								end else begin
									n.os[0] = s.sh[7];
								end
							end
							// Temperature register ignores writes
						end
						2'h3: begin
							// Extra data bytes are acknowledged, not stored
						end
					endcase
				end
			end
			ST_WACK: begin
				if (scl_fall) begin
					n.sda_drv = 1'b0;
					n.st = ST_WBYTE;
				end
			end
			ST_RBYTE: begin
				if (scl_rise) begin
					n.bcnt = s.bcnt + 4'h1;
				end else if (scl_fall) begin
					if (s.bcnt == BITS_BYTE) begin
						n.bcnt = 4'h0;
						n.sda_drv = 1'b0;
						n.st = ST_RACK;
					end else begin
						n.tx = sh_tx;
						n.sda_drv = ~sh_tx[15];
					end
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					rd_done = 1'b1;
					if (pins_s.sda) begin
						n.st = ST_IDLE;
					end
				end else if (scl_fall) begin
					// A byte of zero bits keeps SDA low if the master quits
					n.st = ST_RBYTE;
					if (s.rhalf) begin
						rd_load = 1'b1;
						n.tx = word;
						n.sda_drv = ~word[15];
					end else begin
						n.tx = sh_tx;
						n.sda_drv = ~sh_tx[15];
					end
					n.rhalf = ~s.rhalf;
				end
			end
		endcase

		// Start, stop and lockup recovery override the byte engine
		if (tout_fire || stop_c) begin
			n.st = ST_IDLE;
			n.sda_drv = 1'b0;
		end else if (start_c) begin
			n.st = ST_ADDR;
			n.bcnt = 4'h0;
			n.sda_drv = 1'b0;
		end
	end

	// Alarm evaluation, one step per conversion strobe
	always_comb begin
		conv_eval = conv.valid & ~s.cfg[CFG_SD];
		over = $signed(conv.temp) > $signed(s.os);
		under = $signed(conv.temp) < $signed(s.hyst);
		need = tsa_fq_need(s.cfg[CFG_FQ+1:CFG_FQ]);
		trip_hi = 1'b0;
		trip_lo = 1'b0;
		sd_enter = s.cfg[CFG_SD] & ~s.sd_p;
		if (conv_eval) begin
			// One bit wider so a saturated count does not wrap to zero
			trip_hi = over && ({1'b0, s.ocnt} + 4'h1) >= {1'b0, need};
			trip_lo = under && ({1'b0, s.ucnt} + 4'h1) >= {1'b0, need};
		end
	end

	// Final next-state merge for the alarm fields
	tsa_state_t m;
	always_comb begin
		m = n;
		m.sd_p = s.cfg[CFG_SD];
		if (conv_eval) begin
			m.ocnt = !over ? 3'h0 : (s.ocnt == FQ_SAT ? s.ocnt : s.ocnt + 3'h1);
			m.ucnt = !under ? 3'h0 : (s.ucnt == FQ_SAT ? s.ucnt : s.ucnt + 3'h1);
		end
		// Clears come first so a trip in the same cycle wins
		if (sd_enter) begin
			m.alarm = 1'b0;
			m.look_hi = 1'b1;
		end else if (rd_done && s.cfg[CFG_INT]) begin
			m.alarm = 1'b0;
		end
		if (!s.cfg[CFG_INT]) begin
			m.look_hi = 1'b1;
			if (trip_hi) begin
				m.alarm = 1'b1;
			end else if (trip_lo) begin
				m.alarm = 1'b0;
			end
		end else if (s.look_hi && trip_hi) begin
			m.alarm = 1'b1;
			m.look_hi = 1'b0;
		end else if (!s.look_hi && trip_lo) begin
			m.alarm = 1'b1;
			m.look_hi = 1'b1;
		end
	end

	// Reset must be held RST_MIN_CYC cycles to honour the minimum pulse
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s <= '0;
			s.scl_p <= 1'b1;
			s.sda_p <= 1'b1;
			s.cfg <= CFG_RST;
			s.hyst <= HYST_RST;
			s.os <= OS_RST;
			s.ptr <= PTR_TEMP;
			s.look_hi <= 1'b1;
		end else begin
			s <= m;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe = s.sda_drv;
	assign alarm_output_o = 1'b0;
	// Open drain: pull low when the pin level must read low
	assign alarm_output_oe = s.alarm ^ s.cfg[CFG_POL];
	assign shutdown = s.cfg[CFG_SD];

	property p_sd_clear;
		@(posedge mclk) disable iff (!rst_b)
		sd_enter |=> !s.alarm;
	endproperty
	a_sd_clear: assert property (p_sd_clear)
		else $error("alarm kept through shutdown entry");

	property p_pol;
		@(posedge mclk) disable iff (!rst_b)
		$rose(s.alarm) |-> alarm_output_oe == !s.cfg[CFG_POL];
	endproperty
	a_pol: assert property (p_pol)
		else $error("alarm pin polarity wrong");

	property p_int_hold;
		@(posedge mclk) disable iff (!rst_b)
		s.cfg[CFG_INT] && s.alarm && !rd_done && !sd_enter |=> s.alarm;
	endproperty
	a_int_hold: assert property (p_int_hold)
		else $error("interrupt alarm dropped without read");

	property p_comp_trip;
		@(posedge mclk) disable iff (!rst_b)
		!s.cfg[CFG_INT] && conv_eval && over && need == 3'h1 |=> s.alarm;
	endproperty
	a_comp_trip: assert property (p_comp_trip)
		else $error("comparator alarm missed over limit");

	property p_int_rearm;
		@(posedge mclk) disable iff (!rst_b)
		s.cfg[CFG_INT] && !s.look_hi && !s.alarm && !trip_lo |=> !s.alarm;
	endproperty
	a_int_rearm: assert property (p_int_rearm)
		else $error("interrupt alarm rose without hysteresis crossing");

	property p_thr_lsb;
		@(posedge mclk) disable iff (!rst_b)
		rd_load && s.ptr[1] |=> s.tx[6:0] == 7'h00;
	endproperty
	a_thr_lsb: assert property (p_thr_lsb)
		else $error("threshold low bits not zero on read");

	property p_ptr_hold;
		@(posedge mclk) disable iff (!rst_b)
		!ptr_wr |=> $stable(s.ptr);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold)
		else $error("pointer changed without pointer byte");

	property p_cfg_late;
		@(posedge mclk) disable iff (!rst_b)
		s.st == ST_WBYTE && s.wcnt == 2'h3 |=> $stable(s.cfg);
	endproperty
	a_cfg_late: assert property (p_cfg_late)
		else $error("configuration taken from third data byte");

	property p_tout;
		@(posedge mclk) disable iff (!rst_b)
		tout_fire |=> s.st == ST_IDLE && !sda_oe;
	endproperty
	a_tout: assert property (p_tout)
		else $error("lockup timeout did not free the bus");

	property p_por;
		@(posedge mclk)
		!rst_b |=> s.os == OS_RST && s.hyst == HYST_RST && s.cfg == CFG_RST;
	endproperty
	a_por: assert property (p_por)
		else $error("power-on values not loaded");

	c_read: cover property (@(posedge mclk) disable iff (!rst_b) rd_done);
	c_trip: cover property (@(posedge mclk) disable iff (!rst_b)
		$rose(s.alarm));
	c_tout: cover property (@(posedge mclk) disable iff (!rst_b) tout_fire);
	c_cfgw: cover property (@(posedge mclk) disable iff (!rst_b) cfg_wr);
endmodule : tsa_top
`default_nettype wire

// ===== testbench/tsa_mst.sv
// Two-wire bus master model that drives the alarm block's pins
`timescale 1ns/1ps
`default_nettype none
module tsa_mst (
	input wire logic mclk, // System clock
	input wire logic sda_w, // Resolved data line level
	output logic scl, // Serial clock drive
	output logic sda_m // Data drive, one releases the line
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// Third of a bit of six cycles keeps SCL far above the floor
	task automatic hp();
		repeat (6) @(negedge mclk);
	endtask : hp
	// Also serves as repeated start when SCL is low
	task automatic start();
		sda_m = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_m = 1'b0;
		hp();
		scl = 1'b0;
		hp();
	endtask : start
	// Pulls SDA low first so a stop always follows
	task automatic stop();
		sda_m = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_m = 1'b1;
		hp();
	endtask : stop
	// Eight bits of d then mack; the line is read at each SCL high
	task automatic xfer(input logic [7:0] d, input logic mack,
		output logic [7:0] q, output logic ack);
		logic [8:0] w;
		w = {d, mack};
		for (int i = 8; i >= 0; i--) begin
			sda_m = w[i];
			hp();
			scl = 1'b1;
			hp();
			w[i] = sda_w;
			scl = 1'b0;
			hp();
		end
		q = w[8:1];
		ack = w[0];
	endtask : xfer
endmodule : tsa_mst
`default_nettype wire

// ===== testbench/tsa_top_tb_top.sv
// Self-checking bench of the temperature alarm block
`timescale 1ns/1ps
`default_nettype none
module tsa_top_tb_top;
	import tsa_pkg::*;
	// Longer than the low run of a 16-bit read of zero, about 330 cycles
	localparam logic [TOUT_W-1:0] TLIM = 32'h0000_0258;
	localparam logic [6:0] DEV = 7'h4D;
	logic mclk, rst_b, scl, sda_m, sda_w, sda_o, sda_oe;
	logic pin_o, pin_oe, shutdown, pol;
	logic [2:0] addr_sel;
	tsa_conv_t conv;
	int err_count, checks;
	assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
	tsa_top #(.TOUT_LIMIT(TLIM)) u_tsa_top (.mclk(mclk), .rst_b(rst_b),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.addr_sel(addr_sel), .conv(conv), .alarm_output_o(pin_o),
		.alarm_output_oe(pin_oe), .shutdown(shutdown));
	tsa_mst u_tsa_mst (.mclk(mclk), .sda_w(sda_w), .scl(scl),
		.sda_m(sda_m));
	task automatic report_and_stop();
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic do_reset(input int n);
		@(negedge mclk);
		rst_b = 1'b0;
		repeat (n) @(negedge mclk);
		rst_b = 1'b1;
		pol = 1'b0;
		repeat (3) @(negedge mclk);
	endtask : do_reset
	task automatic wr(input logic [1:0] p, input int n,
		input logic [23:0] d);
		logic [7:0] q;
		logic a;
		u_tsa_mst.start();
		u_tsa_mst.xfer({DEV, 1'b0}, 1'b1, q, a);
		chk(16'(a), 16'h0000);
		u_tsa_mst.xfer({6'h00, p}, 1'b1, q, a);
		for (int i = 0; i < n; i++) begin
			u_tsa_mst.xfer(d[23-8*i -: 8], 1'b1, q, a);
			chk(16'(a), 16'h0000);
		end
		u_tsa_mst.stop();
	endtask : wr
	task automatic rd(input logic [1:0] p, input logic setp,
		output logic [15:0] w);
		logic [7:0] q;
		logic a;
		if (setp) begin
			u_tsa_mst.start();
			u_tsa_mst.xfer({DEV, 1'b0}, 1'b1, q, a);
			u_tsa_mst.xfer({6'h00, p}, 1'b1, q, a);
		end
		u_tsa_mst.start();
		u_tsa_mst.xfer({DEV, 1'b1}, 1'b1, q, a);
		chk(16'(a), 16'h0000);
		u_tsa_mst.xfer(8'hFF, 1'b0, w[15:8], a);
		u_tsa_mst.xfer(8'hFF, 1'b1, w[7:0], a);
		u_tsa_mst.stop();
	endtask : rd
	task automatic cv(input logic [8:0] t);
		@(negedge mclk);
		conv = '{valid: 1'b1, temp: t};
		@(negedge mclk);
		conv.valid = 1'b0;
		repeat (2) @(negedge mclk);
	endtask : cv
	// Pin is pulled low while the alarm is on with pol clear, or off with pol set
	task automatic pin(input logic on);
		chk(16'(pin_oe), 16'(on ^ pol));
		chk(16'(pin_o), 16'h0000);
	endtask : pin
	task automatic t_reset();
		logic [15:0] w;
		wr(PTR_OS, 2, 24'h123400);
		do_reset(RST_MIN_CYC);
		pin(1'b0);
		chk(16'(shutdown), 16'h0000);
		rd(PTR_OS, 1'b0, w);
		chk(w, 16'h0000);
		rd(PTR_OS, 1'b1, w);
		chk(w, 16'h5000);
		rd(PTR_HYST, 1'b1, w);
		chk(w, 16'h4B00);
		rd(PTR_CFG, 1'b1, w);
		chk(w, 16'h0000);
	endtask : t_reset
	task automatic t_thr();
		logic [15:0] w;
		wr(PTR_OS, 3, 24'h7FFF12);
		rd(PTR_OS, 1'b0, w);
		chk(w, 16'h7F80);
		wr(PTR_OS, 1, 24'h550000);
		rd(PTR_OS, 1'b0, w);
		chk(w, 16'h5580);
		wr(PTR_HYST, 2, 24'hFF8000);
		rd(PTR_HYST, 1'b0, w);
		chk(w, 16'hFF80);
	endtask : t_thr
	task automatic t_cfg();
		logic [15:0] w;
		wr(PTR_CFG, 3, 24'h04181F);
		rd(PTR_CFG, 1'b0, w);
		chk(w, 16'h1818);
		cv(9'h032);
		wr(PTR_TEMP, 2, 24'hABCD00);
		rd(PTR_TEMP, 1'b1, w);
		chk(w, 16'h1900);
		cv(9'h1CE);
		rd(PTR_TEMP, 1'b0, w);
		chk(w, 16'hE700);
	endtask : t_cfg
	task automatic t_comp();
		do_reset(5);
		cv(9'h0A0);
		pin(1'b0);
		cv(9'h0A1);
		pin(1'b1);
		cv(9'h096);
		pin(1'b1);
		cv(9'h095);
		pin(1'b0);
		wr(PTR_CFG, 1, 24'h040000);
		pol = 1'b1;
		pin(1'b0);
		cv(9'h0A1);
		pin(1'b1);
		cv(9'h1CE);
		pin(1'b0);
	endtask : t_comp
	task automatic t_fq();
		int need [4] = '{1, 2, 4, 6};
		for (int f = 0; f < 4; f++) begin
			do_reset(5);
			wr(PTR_CFG, 1, {3'h0, 2'(f), 19'h00000});
			for (int k = 1; k < need[f]; k++)
				cv(9'h0A1);
			pin(1'b0);
			cv(9'h0A1);
			pin(1'b1);
		end
	endtask : t_fq
	task automatic t_int();
		logic [15:0] w;
		do_reset(5);
		wr(PTR_CFG, 1, 24'h020000);
		cv(9'h0A1);
		cv(9'h0A1);
		pin(1'b1);
		rd(PTR_CFG, 1'b0, w);
		chk(w, 16'h0202);
		pin(1'b0);
		cv(9'h0A1);
		pin(1'b0);
		cv(9'h090);
		pin(1'b1);
		wr(PTR_CFG, 1, 24'h030000);
		pin(1'b0);
		chk(16'(shutdown), 16'h0001);
	endtask : t_int
	task automatic t_tout();
		logic [15:0] w;
		logic [7:0] q;
		logic a;
		int n;
		do_reset(5);
		wr(PTR_HYST, 0, 24'h000000);
		// Upper byte 4B ends in a one: SDA stays low from the master ACK on
		u_tsa_mst.start();
		u_tsa_mst.xfer({DEV, 1'b1}, 1'b1, q, a);
		chk(16'(a), 16'h0000);
		u_tsa_mst.xfer(8'hFF, 1'b0, q, a);
		chk(16'(q), 16'h004B);
		chk(16'(sda_oe), 16'h0001);
		n = 0;
		while (sda_oe !== 1'b0 && n < 1000) begin
			@(negedge mclk);
			n++;
		end
		// Line was already low for the whole ACK bit, 18 cycles
		chk(16'(n + 18 > TLIM && n + 18 <= TLIM + 8), 16'h0001);
		u_tsa_mst.stop();
		rd(PTR_HYST, 1'b1, w);
		chk(w, 16'h4B00);
	endtask : t_tout
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		#400000;
		err_count++;
		report_and_stop();
	end
	initial begin
		rst_b = 1'b0;
		pol = 1'b0;
		addr_sel = 3'h5;
		conv = '0;
		err_count = 0;
		checks = 0;
		do_reset(5);
		t_reset();
		t_thr();
		t_cfg();
		t_comp();
		t_fq();
		t_int();
		t_tout();
		report_and_stop();
	end
endmodule : tsa_top_tb_top
`default_nettype wire
